//--- rtl/kwu_pkg.sv
// Package with register map, reset values and modes of the key wakeup block
package kwu_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] KWU_ENABLE_OFFSET = 12'hF9F;  // Key wakeup enable, write-only
  localparam logic [11:0] KWU_CONTROL_OFFSET = 12'hFA0;  // Standby control and status
  localparam logic [15:0] KWU_ENABLE_BYTE_ADDR = 16'h3E7C;  // Index times four
  localparam int KWU_ADDR_W = 16;
  localparam logic [15:0] KWU_ENABLE_ADDR = 16'h3E7C;  // Byte address of enable register
  localparam logic [15:0] KWU_CONTROL_ADDR = 16'h3E80;  // Byte address of control register
  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int KWU_KEY_COUNT = 4;
  localparam int KWU_EN_LSB = 4;  // Enable bits 7..4 map keys 3..0
  localparam int KWU_CTL_RELM = 0;  // Release mode select
  localparam int KWU_CTL_STOP = 1;  // Standby-entry request, write 1
  localparam int KWU_STS_STBY = 8;  // In standby
  localparam int KWU_STS_WAKE = 9;  // Wake request level
  localparam logic [3:0] KWU_EN_RESET = 4'h0;
  localparam logic RELM_RESET = 1'b0;
  localparam logic [31:0] KWU_UNDEF_READ = 32'h00000000;  // Read of write-only register
  // ****************************************
  // Standby states
  // ****************************************
  typedef enum logic [1:0] {KWU_RUN, KWU_STANDBY, KWU_WARMUP} kwu_state_type;
endpackage

//--- rtl/kwu_edge_det.sv
// Rising edge detector for the standby-release pin
`timescale 1ns/1ps
module kwu_edge_det (
  input wire logic i_core_clk,  // Core clock
  input wire logic i_sys_rst,  // Async reset, high
  input wire logic i_level,  // Sampled input level
  output logic o_rise  // One-cycle rising edge pulse
);
  logic prev;
  logic next_prev;
  // Next value of delayed level
  always_comb begin
    next_prev = i_level;
  end
  // Delay register
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev <= 1'b1;
    end else begin
      prev <= next_prev;
    end
  end
  assign o_rise = i_level & ~prev;
endmodule

//--- rtl/kwu_key_mask.sv
// Enable-gated low-level detector for one key wakeup pin
`timescale 1ns/1ps
module kwu_key_mask (
  input wire logic i_enable,  // Key enable bit
  input wire logic i_pin,  // Key wakeup pin level, separate input path
  output logic o_active  // Enabled and low
);
  assign o_active = i_enable & ~i_pin;
endmodule

//--- rtl/kwu_top.sv
// Key wakeup standby release block with Avalon-MM registers
// ****************************************
// Summary of operation
// - Four key pins plus release pin wake
// - Bits 7..4 enable key pins 3..0
// - Enable register write-only, upper bits reset zero
// - Level mode: enabled key low releases
// - Release pin: high level or rising edge
// - Wake condition at entry skips standby
// - Release pin always participates, no enable
// - Wake detector uses its own input path
// ****************************************
`timescale 1ns/1ps
module kwu_top (
  input wire logic i_core_clk,  // Core clock, 125 MHz
  input wire logic i_sys_rst,  // Async reset, high
  input wire logic [kwu_pkg::KWU_ADDR_W-1:0] i_avs_address,  // Byte address
  input wire logic i_avs_read,  // Read strobe
  input wire logic i_avs_write,  // Write strobe
  input wire logic [31:0] i_avs_writedata,  // Write data
  input wire logic [3:0] i_avs_byteenable,  // Byte lanes
  output logic [31:0] o_avs_readdata,  // Read data
  output logic o_avs_waitrequest,  // Wait request
  input wire logic [3:0] i_key_wake_in,  // Key wakeup pins 3..0
  input wire logic i_standby_release,  // Dedicated release pin
  output logic o_standby,  // Device is in standby
  output logic o_warmup_start  // One-cycle warm-up start pulse
);
  import kwu_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [3:0] key_en;
  logic [3:0] next_key_en;
  logic release_mode;
  logic next_release_mode;
  kwu_state_type state;
  kwu_state_type next_state;
  logic [31:0] readdata;
  logic [31:0] next_readdata;
  logic ack;
  logic next_ack;
  logic warm;
  logic next_warm;
  logic [3:0] key_active;
  logic pin_rise;
  logic pin_cond;
  logic key_cond;
  logic wake_req;
  logic entry_wake;
  logic acc;
  logic wr_en;
  logic wr_ctl;
  logic stop_cmd;

  // ****************************************
  // Wake detection
  // ****************************************
  // Dedicated detector path
  genvar g;
  generate
    for (g = 0; g < KWU_KEY_COUNT; g++) begin : g_key
      kwu_key_mask u_mask (
        .i_enable(key_en[g]),
        .i_pin(i_key_wake_in[g]),
        .o_active(key_active[g])
      );
    end
  endgenerate

  kwu_edge_det u_edge (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_level(i_standby_release),
    .o_rise(pin_rise)
  );

  assign pin_cond = release_mode ? i_standby_release : pin_rise;
  assign key_cond = release_mode & (|key_active);
  assign wake_req = pin_cond | key_cond;
  assign entry_wake = i_standby_release | (|key_active);

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // Access decode, one wait cycle per access
  // Writes land in the answer cycle, when waitrequest is low
  assign acc = (i_avs_read | i_avs_write) & ~ack;
  assign wr_en = ack & i_avs_write & (i_avs_address == KWU_ENABLE_ADDR) & i_avs_byteenable[0];
  assign wr_ctl = ack & i_avs_write & (i_avs_address == KWU_CONTROL_ADDR) & i_avs_byteenable[0];
  assign stop_cmd = wr_ctl & i_avs_writedata[KWU_CTL_STOP];
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;

  // Register and bus next values
  always_comb begin
    next_key_en = key_en;
    next_release_mode = release_mode;
    next_readdata = readdata;
    next_ack = acc;
    if (wr_en) begin
      next_key_en = i_avs_writedata[KWU_EN_LSB +: KWU_KEY_COUNT];
    end
    if (wr_ctl) begin
      next_release_mode = i_avs_writedata[KWU_CTL_RELM];
    end
    if (acc & i_avs_read) begin
      next_readdata = 32'h00000000;
      unique case (i_avs_address)
        KWU_ENABLE_ADDR: next_readdata = KWU_UNDEF_READ;
        KWU_CONTROL_ADDR: begin
          next_readdata[KWU_CTL_RELM] = release_mode;
          next_readdata[KWU_STS_STBY] = (state == KWU_STANDBY);
          next_readdata[KWU_STS_WAKE] = wake_req;
        end
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      key_en <= KWU_EN_RESET;
      release_mode <= RELM_RESET;
      readdata <= 32'h00000000;
      ack <= 1'b0;
    end else begin
      key_en <= next_key_en;
      release_mode <= next_release_mode;
      readdata <= next_readdata;
      ack <= next_ack;
    end
  end
  assign o_avs_readdata = readdata;

  // ****************************************
  // Standby sequencer
  // ****************************************
  // Next state and warm-up pulse
  always_comb begin
    next_state = state;
    next_warm = 1'b0;
    unique case (state)
      KWU_RUN: begin
        if (stop_cmd) begin
          if (entry_wake) begin
            next_state = KWU_WARMUP;
          end else begin
            next_state = KWU_STANDBY;
          end
        end
      end
      KWU_STANDBY: begin
        if (wake_req) begin
          next_state = KWU_WARMUP;
        end
      end
      KWU_WARMUP: begin
        next_warm = 1'b1;
        next_state = KWU_RUN;
      end
      default: next_state = KWU_RUN;
    endcase
  end

  // State registers
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= KWU_RUN;
      warm <= 1'b0;
    end else begin
      state <= next_state;
      warm <= next_warm;
    end
  end
  assign o_standby = (state == KWU_STANDBY);
  assign o_warmup_start = warm;

  // ****************************************
  // Assertions
  // ****************************************
  key_level_wake_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_STANDBY && release_mode && (|(key_en & ~i_key_wake_in))) |=> state == KWU_WARMUP)
    else $error("enabled low key did not wake");
  key_edge_ignore_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_STANDBY && !release_mode && !pin_rise) |=> state == KWU_STANDBY)
    else $error("edge mode woke without rising edge");
  pin_level_wake_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_STANDBY && release_mode && i_standby_release) |=> ##1 o_warmup_start)
    else $error("release pin level did not wake");
  disabled_key_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_STANDBY && !i_standby_release && key_en == 4'h0) |=> state == KWU_STANDBY)
    else $error("disabled key woke");
  entry_skip_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_RUN && stop_cmd && i_standby_release) |=> !o_standby ##1 o_warmup_start)
    else $error("standby entered despite pending wake");
  enable_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_en |=> key_en == $past(i_avs_writedata[7:4]))
    else $error("enable write not stored");
  read_keeps_en_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (acc && i_avs_read) |=> $stable(key_en))
    else $error("read altered enables");
  wake_or_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wake_req == ((release_mode ? i_standby_release : pin_rise) | (release_mode & |(key_en & ~i_key_wake_in))))
    else $error("wake request mis-formed");
  bus_answer_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_avs_read && !ack) |=> !o_avs_waitrequest)
    else $error("bus answer late");
  wait_first_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ((i_avs_read || i_avs_write) && !ack) |-> o_avs_waitrequest)
    else $error("bus answered without wait");
  key_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !wr_en |=> $stable(key_en))
    else $error("enables changed without write");
  mode_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !wr_ctl |=> $stable(release_mode))
    else $error("release mode changed without write");

  // Release sequence shape
  edge_pin_wake_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_STANDBY && !release_mode && pin_rise) |=> state == KWU_WARMUP)
    else $error("rising release edge did not wake");
  edge_low_pin_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_STANDBY && !release_mode && !i_standby_release) |=> o_standby)
    else $error("edge mode woke with release pin low");
  pin_always_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_STANDBY && release_mode && i_standby_release) |=> state == KWU_WARMUP)
    else $error("release pin ignored in level mode");
  warmup_run_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_WARMUP) |=> (state == KWU_RUN && o_warmup_start))
    else $error("warm-up did not return to run");
  warm_single_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_warmup_start |=> !o_warmup_start)
    else $error("warm-up pulse longer than one cycle");
  pulse_run_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_warmup_start |-> state == KWU_RUN)
    else $error("warm-up pulse outside run state");

  // Entry-time checks, key mode and detector path
  entry_key_skip_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_RUN && stop_cmd && (|key_active)) |=> !o_standby ##1 o_warmup_start)
    else $error("standby entered despite low enabled key");
  entry_enter_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_RUN && stop_cmd && !entry_wake) |=> o_standby)
    else $error("standby not entered");
  standby_stop_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == KWU_STANDBY && stop_cmd && !wake_req) |=> o_standby)
    else $error("entry write disturbed standby");
  key_mode_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !release_mode |-> !key_cond)
    else $error("key wake outside level mode");
  detect_path_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    key_active == (key_en & ~i_key_wake_in))
    else $error("key detector path wrong");

  // Register reads
  read_enable_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ack && i_avs_read && i_avs_address == KWU_ENABLE_ADDR) |-> o_avs_readdata == KWU_UNDEF_READ)
    else $error("enable read value wrong");
  read_mode_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ack && i_avs_read && i_avs_address == KWU_CONTROL_ADDR) |-> o_avs_readdata[KWU_CTL_RELM] == release_mode)
    else $error("release mode read wrong");
  read_standby_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ack && i_avs_read && i_avs_address == KWU_CONTROL_ADDR) |->
    o_avs_readdata[KWU_STS_STBY] == $past(o_standby))
    else $error("standby status read wrong");
  read_unmapped_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ack && i_avs_read && i_avs_address != KWU_ENABLE_ADDR && i_avs_address != KWU_CONTROL_ADDR) |->
    o_avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");

  cover_key_wake: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state == KWU_STANDBY && key_cond ##1 state == KWU_WARMUP);
  cover_edge_wake: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state == KWU_STANDBY && !release_mode && pin_rise);
  cover_skip: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state == KWU_RUN && stop_cmd && entry_wake);
  // Level release by the dedicated pin, and status reads
  cover_level_pin: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state == KWU_STANDBY && release_mode && i_standby_release);
  cover_read_ctl: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ack && i_avs_read && i_avs_address == KWU_CONTROL_ADDR);
endmodule

//--- sim/kwu_keys.sv
// Model of the external keys and release switch
`timescale 1ns/1ps
module kwu_keys (
  input wire logic i_core_clk,  // Core clock
  input wire logic [3:0] i_press,  // Keys pressed 3..0
  input wire logic i_release,  // Release switch closed
  output logic [3:0] o_key_wake_in,  // Key pin levels
  output logic o_standby_release  // Release pin level
);
  // Pull-ups keep idle keys high
  initial o_key_wake_in = 4'hF;
  initial o_standby_release = 1'b0;
  always @(posedge i_core_clk) begin
    o_key_wake_in <= ~i_press;
    o_standby_release <= i_release;
  end
endmodule

//--- sim/tb.sv
// Self-checking bench of the key wakeup block
`timescale 1ns/1ps
module tb;
  import kwu_pkg::*;
  logic clk, rst = 1'b1, rd = 1'b0, wr = 1'b0, rel = 1'b0, wreq, rel_pin, stby, warm;
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [3:0] press = 4'h0, keys;
  int n_fail = 0, compares = 0, n_warm = 0, n_stby = 0;
  kwu_top kwu_top_i (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_key_wake_in(keys), .i_standby_release(rel_pin), .o_standby(stby),
    .o_warmup_start(warm));
  kwu_keys kwu_keys_i (.i_core_clk(clk), .i_press(press), .i_release(rel), .o_key_wake_in(keys),
    .o_standby_release(rel_pin));
  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counts warm-up pulses and standby cycles
  always @(posedge clk) begin
    if (warm === 1'b1) n_warm++;
    if (stby === 1'b1) n_stby++;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      stop_test;
    end
  endtask
  task automatic pins(input logic [3:0] p, input logic r);
    @(posedge clk);
    press <= p;
    rel <= r;
  endtask
  // Checks pulses and standby level over eight cycles
  task automatic watch(input int pulses, input logic sb);
    int c;
    c = n_warm;
    repeat (8) @(negedge clk);
    check(n_warm - c, pulses);
    check({31'h0, stby}, {31'h0, sb});
  endtask
  task automatic enter(input logic [31:0] en, input logic lvl);
    bus(1'b1, KWU_ENABLE_ADDR, en);
    bus(1'b1, KWU_CONTROL_ADDR, {31'h0, lvl});
    bus(1'b1, KWU_CONTROL_ADDR, {30'h0, 1'b1, lvl});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    check({31'h0, stby}, 32'h0);
    bus(1'b0, KWU_ENABLE_ADDR, 32'h0);
    check(q, KWU_UNDEF_READ);
    pins(4'hF, 1'b0);
    bus(1'b1, KWU_CONTROL_ADDR, 32'h1);
    bus(1'b1, KWU_CONTROL_ADDR, 32'h3);
    watch(0, 1'b1);
    pins(4'hF, 1'b1);
    watch(1, 1'b0);
    pins(4'h0, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_keys;
    for (int k = 0; k < 4; k++) begin
      enter(32'h10 << k, 1'b1);
      bus(1'b0, KWU_ENABLE_ADDR, 32'h0);
      pins(4'hF ^ (4'h1 << k), 1'b0);
      watch(0, 1'b1);
      pins(4'hF, 1'b0);
      watch(1, 1'b0);
      pins(4'h0, 1'b0);
    end
    $display("test keys done");
  endtask
  task automatic t_edge;
    enter(32'hF0, 1'b0);
    pins(4'hF, 1'b0);
    watch(0, 1'b1);
    bus(1'b0, KWU_CONTROL_ADDR, 32'h0);
    check(q, 32'h00000100);
    pins(4'hF, 1'b1);
    watch(1, 1'b0);
    pins(4'h0, 1'b0);
    $display("test edge done");
  endtask
  task automatic t_skip;
    int s;
    pins(4'h2, 1'b0);
    s = n_stby;
    enter(32'h20, 1'b1);
    watch(1, 1'b0);
    check(n_stby - s, 0);
    pins(4'h0, 1'b1);
    enter(32'h0, 1'b0);
    watch(1, 1'b0);
    check(n_stby - s, 0);
    pins(4'h0, 1'b0);
    $display("test skip done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_keys;
    t_edge;
    t_skip;
    stop_test;
  end
endmodule
